// [ledps_defines.svh]
// timing constants of the led driver protection supervisor
// assumes ref_clk at 10 MHz; counts derive from times in ns
`ifndef LEDPS_DEFINES_SVH
`define LEDPS_DEFINES_SVH

// -----------------------------------------------------------------
// clock
// -----------------------------------------------------------------
`define LEDPS_CLK_NS 100

// -----------------------------------------------------------------
// times in ns
// -----------------------------------------------------------------
// least times: leading-edge blanking, overcurrent turn-off delay
`define LEDPS_LEB_NS 300
`define LEDPS_OCPD_NS 100
// longest times: on-time limit, off-time limit
`define LEDPS_ON_MAX_NS 20000
`define LEDPS_OFF_MAX_NS 30000
// short-circuit detection and thermistor timeout
`define LEDPS_SC_NS 2000000
`define LEDPS_NTC_TO_NS 5000000

// -----------------------------------------------------------------
// cycle counts (least rounds up, longest rounds down)
// -----------------------------------------------------------------
`define LEDPS_LEB_CYC \
  ((`LEDPS_LEB_NS + `LEDPS_CLK_NS - 1) / `LEDPS_CLK_NS)
`define LEDPS_OCPD_CYC \
  ((`LEDPS_OCPD_NS + `LEDPS_CLK_NS - 1) / `LEDPS_CLK_NS)
`define LEDPS_ON_MAX_CYC (`LEDPS_ON_MAX_NS / `LEDPS_CLK_NS)
`define LEDPS_OFF_MAX_CYC (`LEDPS_OFF_MAX_NS / `LEDPS_CLK_NS)
`define LEDPS_SC_CYC (`LEDPS_SC_NS / `LEDPS_CLK_NS)
`define LEDPS_NTC_TO_CYC (`LEDPS_NTC_TO_NS / `LEDPS_CLK_NS)

// -----------------------------------------------------------------
// widths
// -----------------------------------------------------------------
`define LEDPS_CNT_W 16
`define LEDPS_CMP_W 11

`endif

// [ledps_pkg.sv]
// types of the led driver protection supervisor
// assumes ledps_defines.svh is on the include path
package ledps_pkg;
`include "ledps_defines.svh"

  // comparator levels, each high while its condition holds
  typedef struct packed {
    logic vcc_lt_rst;
    logic vcc_lt_stop;
    logic vcc_lt_regon;
    logic cs_peak;
    logic die_hot;
    logic die_cool;
    logic valley;
    logic ntc_gt_high;
    logic ntc_gt_low;
    logic ntc_lt_tstart;
    logic ntc_lt_tstop;
  } ledps_cmp_s;

  typedef enum logic [1:0] {
    PK_NOMINAL,
    PK_GRADED,
    PK_HALF,
    PK_ZERO
  } ledps_peak_e;

  typedef struct packed {
    logic gate;
    logic restart_en;
    logic regulator_en;
    logic short_fault;
    logic die_overheat;
    logic led_overtemp;
    logic pwm_off;
    ledps_peak_e peak_sel;
  } ledps_out_s;

  typedef enum logic [1:0] {
    CV_IDLE,
    CV_ON,
    CV_OCPD,
    CV_OFF
  } ledps_conv_e;

  typedef logic [`LEDPS_CNT_W-1:0] ledps_cnt_t;
  typedef logic [`LEDPS_CMP_W-1:0] ledps_vec_t;

  typedef struct packed {
    ledps_vec_t s1;
    ledps_vec_t s2;
    ledps_vec_t s3;
    ledps_vec_t stab;
    ledps_conv_e conv;
    ledps_cnt_t cnt;
    logic sc_run;
    ledps_cnt_t sc_cnt;
    logic tmr_run;
    ledps_cnt_t tmr_cnt;
    ledps_out_s o;
  } ledps_state_s;
endpackage

// [ledps_supervisor.sv]
// protection and switch-gating supervisor of a boundary-conduction
// led converter
// assumes comparator levels arrive asynchronously from analog blocks;
// the gate output feeds the external switch driver
//
// Notes on behaviour
// - output short fault is latched and stops switching until power cycling
// - latched short fault clears while supply is below reset level
// - die and led overheat restart automatically once they clear
// - a switching cycle starts only while no fault is active
// - below stop level switching halts and high-voltage restart is enabled
// - current sense is ignored for the blanking time after turn-on
// - peak current turns the switch off after the propagation delay
// - die overheat stops switching until the release level is passed
// - switch turns off when the maximum on-time is reached
// - off-time limit without valley starts the short detect timer
// - valid valley or supply below stop level resets that timer
// - reaching the on-time limit also resets that timer
// - timer expiry without reset declares a short and latches the fault
// - auxiliary regulator is on while supply is below its enable level
// - thermistor above high threshold gives nominal peak current
// - between thresholds peak drops gradually to half at low threshold
// - thermistor below timer start level starts the timeout timer
// - timeout without reaching stop level flags led overheat and restarts
// - led overheat clears only above the thermistor high threshold
// - stop level reached in time forces zero current, no restart
// - zero current ends when thermistor rises above low threshold
`timescale 1ns/1ns
`include "ledps_defines.svh"

module ledps_supervisor #(
  parameter int LEB_CYC = `LEDPS_LEB_CYC,
  parameter int OCPD_CYC = `LEDPS_OCPD_CYC,
  parameter int ON_MAX_CYC = `LEDPS_ON_MAX_CYC,
  parameter int OFF_MAX_CYC = `LEDPS_OFF_MAX_CYC,
  parameter int SC_CYC = `LEDPS_SC_CYC,
  parameter int NTC_TO_CYC = `LEDPS_NTC_TO_CYC
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire ledps_pkg::ledps_cmp_s cmp_in,
  output ledps_pkg::ledps_out_s status
);
  import ledps_pkg::*;

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  ledps_state_s st_reg;
  ledps_state_s st_next;
  ledps_cmp_s lv;
  ledps_vec_t agree;
  logic fault;
  logic sc_rst;
  logic sc_start;
  logic sc_expire;
  logic onmax_ev;
  logic valley_ev;
  logic offmax_ev;

  assign lv = st_reg.stab;
  assign status = st_reg.o;

  // -----------------------------------------------------------------
  // next-state logic
  // -----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    onmax_ev = 1'b0;
    valley_ev = 1'b0;
    offmax_ev = 1'b0;

    // three-stage synchroniser; a level counts once stages 2 and 3 agree
    st_next.s1 = cmp_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    agree = ~(st_reg.s2 ^ st_reg.s3);
    st_next.stab = (agree & st_reg.s3) | (~agree & st_reg.stab);

    // die overheat with hysteresis, restarts by itself
    if (lv.die_hot) begin
      st_next.o.die_overheat = 1'b1;
    end else if (lv.die_cool) begin
      st_next.o.die_overheat = 1'b0;
    end

    // auxiliary supply regulator
    st_next.o.regulator_en = lv.vcc_lt_regon;

    // thermistor releases
    if (st_reg.o.pwm_off && lv.ntc_gt_low) begin
      st_next.o.pwm_off = 1'b0;
    end
    if (st_reg.o.led_overtemp && lv.ntc_gt_high) begin
      st_next.o.led_overtemp = 1'b0;
    end

    // thermistor timeout separates overheat from external pull-down
    if (st_reg.tmr_run) begin
      if (lv.ntc_lt_tstop) begin
        st_next.o.pwm_off = 1'b1;
        st_next.tmr_run = 1'b0;
      end else if (st_reg.tmr_cnt == ledps_cnt_t'(NTC_TO_CYC - 1)) begin
        st_next.o.led_overtemp = 1'b1;
        st_next.tmr_run = 1'b0;
      end else if (!lv.ntc_lt_tstart) begin
        st_next.tmr_run = 1'b0;
      end else begin
        st_next.tmr_cnt = st_reg.tmr_cnt + 1'b1;
      end
    end else if (lv.ntc_lt_tstart && !st_reg.o.pwm_off &&
                 !st_reg.o.led_overtemp) begin
      st_next.tmr_run = 1'b1;
      st_next.tmr_cnt = '0;
    end

    // peak current reference from thermistor level
    if (st_next.o.pwm_off) begin
      st_next.o.peak_sel = PK_ZERO;
    end else if (lv.ntc_gt_high) begin
      st_next.o.peak_sel = PK_NOMINAL;
    end else if (lv.ntc_gt_low) begin
      st_next.o.peak_sel = PK_GRADED;
    end else begin
      st_next.o.peak_sel = PK_HALF;
    end

    // high-voltage restart source
    st_next.o.restart_en = lv.vcc_lt_stop | st_next.o.led_overtemp;

    // any active fault blocks switching
    fault = st_reg.o.short_fault | st_reg.o.die_overheat |
            st_reg.o.led_overtemp | st_reg.o.pwm_off | lv.vcc_lt_stop;

    // converter cycle
    case (st_reg.conv)
      CV_IDLE: begin
        st_next.o.gate = 1'b0;
        if (!fault) begin
          st_next.conv = CV_ON;
          st_next.cnt = '0;
          st_next.o.gate = 1'b1;
        end
      end
      CV_ON: begin
        if (fault) begin
          st_next.conv = CV_IDLE;
          st_next.o.gate = 1'b0;
        end else if (st_reg.cnt == ledps_cnt_t'(ON_MAX_CYC - 1)) begin
          onmax_ev = 1'b1;
          st_next.conv = CV_OFF;
          st_next.cnt = '0;
          st_next.o.gate = 1'b0;
        end else if (lv.cs_peak &&
                     st_reg.cnt >= ledps_cnt_t'(LEB_CYC)) begin
          st_next.conv = CV_OCPD;
          st_next.cnt = '0;
        end else begin
          st_next.cnt = st_reg.cnt + 1'b1;
        end
      end
      CV_OCPD: begin
        if (fault) begin
          st_next.conv = CV_IDLE;
          st_next.o.gate = 1'b0;
        end else if (st_reg.cnt == ledps_cnt_t'(OCPD_CYC - 1)) begin
          st_next.conv = CV_OFF;
          st_next.cnt = '0;
          st_next.o.gate = 1'b0;
        end else begin
          st_next.cnt = st_reg.cnt + 1'b1;
        end
      end
      CV_OFF: begin
        st_next.o.gate = 1'b0;
        if (lv.valley ||
            st_reg.cnt == ledps_cnt_t'(OFF_MAX_CYC - 1)) begin
          valley_ev = lv.valley;
          offmax_ev = !lv.valley;
          st_next.cnt = '0;
          if (fault) begin
            st_next.conv = CV_IDLE;
          end else begin
            st_next.conv = CV_ON;
            st_next.o.gate = 1'b1;
          end
        end else begin
          st_next.cnt = st_reg.cnt + 1'b1;
        end
      end
      default: begin
        st_next.conv = CV_IDLE;
        st_next.o.gate = 1'b0;
      end
    endcase

    // short detect timer
    sc_rst = valley_ev | lv.vcc_lt_stop | onmax_ev;
    sc_start = offmax_ev;
    sc_expire = 1'b0;
    if (sc_rst) begin
      st_next.sc_run = 1'b0;
    end else if (st_reg.sc_run) begin
      if (st_reg.sc_cnt == ledps_cnt_t'(SC_CYC - 1)) begin
        sc_expire = 1'b1;
        st_next.sc_run = 1'b0;
      end else begin
        st_next.sc_cnt = st_reg.sc_cnt + 1'b1;
      end
    end else if (sc_start) begin
      st_next.sc_run = 1'b1;
      st_next.sc_cnt = '0;
    end

    // latched short fault; a new expiry wins over the reset level
    if (lv.vcc_lt_rst) begin
      st_next.o.short_fault = 1'b0;
    end
    if (sc_expire) begin
      st_next.o.short_fault = 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  blank_ignore_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (st_reg.conv == CV_ON && st_reg.cnt < ledps_cnt_t'(LEB_CYC))
      |=> st_reg.conv != CV_OCPD)
    else $error("current sense taken inside blanking");

  ocp_off_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (st_reg.conv == CV_OCPD && !fault &&
     st_reg.cnt == ledps_cnt_t'(OCPD_CYC - 1))
      |=> !status.gate && st_reg.conv == CV_OFF)
    else $error("switch not off after overcurrent delay");

  on_limit_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (st_reg.conv == CV_ON && !fault &&
     st_reg.cnt == ledps_cnt_t'(ON_MAX_CYC - 1))
      |=> !status.gate && !st_reg.sc_run)
    else $error("on-time limit missed");

  sc_start_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (st_reg.conv == CV_OFF && !lv.valley && !lv.vcc_lt_stop &&
     !st_reg.sc_run && st_reg.cnt == ledps_cnt_t'(OFF_MAX_CYC - 1))
      |=> st_reg.sc_run && st_reg.sc_cnt == '0)
    else $error("short timer not started");

  sc_reset_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    lv.vcc_lt_stop |=> !st_reg.sc_run)
    else $error("short timer runs below stop level");

  sc_latch_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (st_reg.sc_run && !sc_rst &&
     st_reg.sc_cnt == ledps_cnt_t'(SC_CYC - 1))
      |=> status.short_fault ##1 !status.gate)
    else $error("short expiry not latched");

  latch_hold_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (status.short_fault && !lv.vcc_lt_rst) |=> status.short_fault)
    else $error("short fault dropped without reset level");

  latch_clear_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (lv.vcc_lt_rst && !sc_expire) |=> !status.short_fault)
    else $error("short fault kept below reset level");

  no_start_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    fault |=> !status.gate)
    else $error("switching during a fault");

  regulator_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    ##1 status.regulator_en == $past(lv.vcc_lt_regon))
    else $error("regulator enable wrong");

  led_restart_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    status.led_overtemp |-> status.restart_en && !status.pwm_off)
    else $error("led overheat without restart");

  pwm_zero_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    status.pwm_off |-> status.peak_sel == PK_ZERO &&
      (!status.restart_en || $past(lv.vcc_lt_stop)))
    else $error("pwm off without zero current");

  die_trip_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    lv.die_hot |=> status.die_overheat)
    else $error("die overheat not raised");

  die_release_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (!lv.die_hot && lv.die_cool) |=> !status.die_overheat)
    else $error("die overheat not released");

  ntc_timer_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (lv.ntc_lt_tstart && !st_reg.tmr_run && !status.pwm_off &&
     !status.led_overtemp)
      |=> st_reg.tmr_run && st_reg.tmr_cnt == '0)
    else $error("thermistor timer not started");

  ntc_timeout_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (st_reg.tmr_run && !lv.ntc_lt_tstop &&
     st_reg.tmr_cnt == ledps_cnt_t'(NTC_TO_CYC - 1))
      |=> status.led_overtemp && status.restart_en && !st_reg.tmr_run)
    else $error("thermistor timeout not flagged");

  pwm_release_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (status.pwm_off && lv.ntc_gt_low) |=> !status.pwm_off)
    else $error("pwm off kept above low threshold");

  led_hold_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (status.led_overtemp && !lv.ntc_gt_high) |=> status.led_overtemp)
    else $error("led overheat dropped below high threshold");

  peak_nominal_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (!status.pwm_off && !st_reg.tmr_run && lv.ntc_gt_high)
      |=> status.peak_sel == PK_NOMINAL)
    else $error("nominal peak not selected");

  sync_agree_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (st_reg.s2 == st_reg.s3) |=> st_reg.stab == $past(st_reg.s3))
    else $error("agreed level not taken");

endmodule // ledps_supervisor

// [ledps_power_stage.sv]
// far-side model: switch current ramp and drain ringing valley
// assumes gate from the supervisor; outputs change after rising edge
`timescale 1ns/1ns
module ledps_power_stage (
  input wire logic ref_clk,
  input wire logic gate,
  input wire logic [31:0] peak_cyc,
  input wire logic [31:0] valley_cyc,
  output logic cs_peak,
  output logic valley
);
  int on_n = 0;
  int off_n = 0;
  initial begin
    cs_peak = 1'b0;
    valley = 1'b0;
  end
  // a zero count means the level is never reached
  always @(posedge ref_clk) begin
    on_n <= gate ? on_n + 1 : 0;
    off_n <= gate ? 0 : off_n + 1;
    cs_peak <= gate && peak_cyc > 0 && on_n >= peak_cyc;
    valley <= !gate && valley_cyc > 0 && off_n >= valley_cyc;
  end
endmodule // ledps_power_stage

// [testbench.sv]
// self-checking bench of the led driver protection supervisor
// assumes ledps_pkg and ledps_power_stage are compiled before it
`timescale 1ns/1ns
module testbench;
  import ledps_pkg::*;
  localparam int LEB = 10;
  localparam int OCPD = 1;
  localparam int ON_MAX = 200;
  localparam int OFF_MAX = 300;
  localparam int SC = 400;
  localparam int NTC_TO = 40;
  // status bit positions
  localparam int GB = 8;
  localparam int SB = 5;
  logic ref_clk;
  logic rstn;
  ledps_cmp_s drv;
  ledps_cmp_s cmp_in;
  ledps_out_s st;
  logic cs_peak;
  logic valley;
  logic [31:0] peak_cyc;
  logic [31:0] valley_cyc;
  int n_errors;
  int total_checks;
  int seed;
  int n;
  int lvl;

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  always_comb begin
    cmp_in = drv;
    cmp_in.cs_peak = cs_peak;
    cmp_in.valley = valley;
  end

  ledps_supervisor #(
    .LEB_CYC(LEB),
    .OCPD_CYC(OCPD),
    .ON_MAX_CYC(ON_MAX),
    .OFF_MAX_CYC(OFF_MAX),
    .SC_CYC(SC),
    .NTC_TO_CYC(NTC_TO)
  ) dut (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .cmp_in(cmp_in),
    .status(st)
  );

  ledps_power_stage stage (
    .ref_clk(ref_clk),
    .gate(st.gate),
    .peak_cyc(peak_cyc),
    .valley_cyc(valley_cyc),
    .cs_peak(cs_peak),
    .valley(valley)
  );

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_win(string what, int lo, int hi, int got);
    total_checks++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("Error %s expected %0d to %0d seen %0d", what, lo, hi, got);
    end
  endtask

  task automatic cyc(int k);
    repeat (k) @(negedge ref_clk);
  endtask

  task automatic wait_bit(int b, logic v, int lim, output int k);
    k = 0;
    while (st[b] !== v) begin
      @(negedge ref_clk);
      k++;
      if (k > lim) begin
        n_errors++;
        $display("Error wait bit %0d expected %h seen %h", b, v, st[b]);
        close_out();
      end
    end
  endtask

  // length of the next full on period
  task automatic on_len(output int k);
    wait_bit(GB, 1'b0, ON_MAX + 20, k);
    wait_bit(GB, 1'b1, OFF_MAX + 20, k);
    wait_bit(GB, 1'b0, ON_MAX + 20, k);
  endtask

  // thermistor band 0 (lowest) to 4: gt_high gt_low lt_tstart lt_tstop
  task automatic set_ntc(int b);
    logic [3:0] v;
    v = b == 4 ? 4'hc : b == 3 ? 4'h4 : b == 2 ? 4'h0 : b == 1 ? 4'h2 : 4'h3;
    {drv.ntc_gt_high, drv.ntc_gt_low, drv.ntc_lt_tstart, drv.ntc_lt_tstop} = v;
  endtask

  function automatic ledps_peak_e exp_peak(int b);
    return b == 4 ? PK_NOMINAL : b == 3 ? PK_GRADED : PK_HALF;
  endfunction

  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  initial begin
    seed = 33249;
    n_errors = 0;
    total_checks = 0;
    rstn = 1'b0;
    drv = '0;
    set_ntc(4);
    peak_cyc = 1;
    valley_cyc = 5;
    cyc(3);
    chk("status in reset", 0, st);
    rstn = 1'b1;
    wait_bit(GB, 1'b1, 10, n);
    on_len(n);
    chk_win("blanked on", LEB + OCPD, LEB + OCPD + 8, n);
    for (int i = 0; i < 8; i++) begin
      peak_cyc = 10 + $unsigned($random(seed)) % 40;
      valley_cyc = 5 + $unsigned($random(seed)) % 30;
      lvl = 2 + $unsigned($random(seed)) % 3;
      set_ntc(lvl);
      on_len(n);
      chk_win("on time", peak_cyc + OCPD, peak_cyc + OCPD + 8, n);
      chk("peak sel", exp_peak(lvl), st.peak_sel);
      wait_bit(GB, 1'b1, OFF_MAX + 20, n);
      chk_win("off time", valley_cyc, valley_cyc + 8, n);
    end
    set_ntc(4);
    peak_cyc = 10;
    valley_cyc = 0;
    on_len(n);
    wait_bit(GB, 1'b1, OFF_MAX + 20, n);
    chk_win("off limit", OFF_MAX - 1, OFF_MAX + 1, n);
    valley_cyc = 5;
    cyc(SC + 100);
    chk("short after valley", 0, st.short_fault);
    peak_cyc = 0;
    valley_cyc = 0;
    on_len(n);
    chk_win("on limit", ON_MAX - 1, ON_MAX + 1, n);
    cyc(3 * (ON_MAX + OFF_MAX));
    chk("short on limit", 0, st.short_fault);
    peak_cyc = 10;
    wait_bit(SB, 1'b1, 3 * SC, n);
    valley_cyc = 5;
    cyc(ON_MAX + OFF_MAX);
    chk("gate latched", 0, st.gate);
    chk("short latched", 1, st.short_fault);
    drv.vcc_lt_regon = 1'b1;
    cyc(5);
    chk("regulator", 1, st.regulator_en);
    drv.vcc_lt_stop = 1'b1;
    cyc(5);
    chk("restart", 1, st.restart_en);
    chk("short above reset", 1, st.short_fault);
    drv.vcc_lt_rst = 1'b1;
    cyc(5);
    chk("short below reset", 0, st.short_fault);
    chk("gate below stop", 0, st.gate);
    drv.vcc_lt_rst = 1'b0;
    drv.vcc_lt_stop = 1'b0;
    cyc(5);
    chk("restart", 0, st.restart_en);
    drv.vcc_lt_regon = 1'b0;
    cyc(5);
    chk("regulator", 0, st.regulator_en);
    wait_bit(GB, 1'b1, 20, n);
    drv.die_hot = 1'b1;
    cyc(6);
    chk("die hot", 1, st.die_overheat);
    chk("gate die hot", 0, st.gate);
    drv.die_hot = 1'b0;
    cyc(20);
    chk("die between", 1, st.die_overheat);
    drv.die_cool = 1'b1;
    cyc(5);
    chk("die cool", 0, st.die_overheat);
    wait_bit(GB, 1'b1, 20, n);
    drv.die_cool = 1'b0;
    set_ntc(1);
    cyc(10);
    set_ntc(0);
    cyc(6);
    chk("pwm off", 1, st.pwm_off);
    chk("zero peak", PK_ZERO, st.peak_sel);
    cyc(NTC_TO + 20);
    chk("pwm restart", 0, st.restart_en);
    chk("pwm led hot", 0, st.led_overtemp);
    chk("pwm gate", 0, st.gate);
    set_ntc(3);
    cyc(6);
    chk("pwm off", 0, st.pwm_off);
    chk("graded peak", PK_GRADED, st.peak_sel);
    wait_bit(GB, 1'b1, 20, n);
    set_ntc(1);
    cyc(NTC_TO - 10);
    chk("led hot early", 0, st.led_overtemp);
    cyc(20);
    chk("led hot", 1, st.led_overtemp);
    chk("led restart", 1, st.restart_en);
    chk("led gate", 0, st.gate);
    set_ntc(3);
    cyc(8);
    chk("led hot low band", 1, st.led_overtemp);
    set_ntc(4);
    cyc(6);
    chk("led hot high band", 0, st.led_overtemp);
    chk("nominal peak", PK_NOMINAL, st.peak_sel);
    wait_bit(GB, 1'b1, 20, n);
    close_out();
  end
endmodule // testbench
